// *** hdl/base_window_decode.sv ***
`timescale 1ns/1ps
module base_window_decode
   import port_cfg_pkg::*;
(
   input  wire logic [HOST_ADDR_W-1:0] io_addr,
   input  wire logic                   aen,
   input  wire logic [BASE_SW_W-1:0]   base_switch_on,
   input  wire logic                   host_16bit,
   output logic      [HOST_ADDR_W-1:0] base_addr,
   output logic                        base_legal,
   output logic                        addr_match
);

   // Switch on reads as zero
   assign base_addr = {~base_switch_on, 3'h0};

   // Narrow hosts only see the upper half of the map
   always_comb begin
      if (host_16bit) begin
         base_legal = (base_addr >= BASE_MIN_WIDE) &&
                      !((base_addr >= BASE_HOLE_LO) && (base_addr <= BASE_HOLE_HI));
      end else begin
         base_legal = (base_addr >= BASE_MIN_NARROW);
      end
   end

   // DMA cycles carry aen high and must never hit the port
   assign addr_match = (io_addr[9:3] == base_addr[9:3]) && !aen;

endmodule : base_window_decode

// *** hdl/port_cfg_pkg.sv ***
package port_cfg_pkg;

   // Register bus geometry
   localparam int REG_ADDR_W = 4;
   localparam int REG_DATA_W = 8;

   // Register offsets
   localparam logic [3:0] OFS_CONTROL   = 4'h0;
   localparam logic [3:0] OFS_STATUS    = 4'h1;
   localparam logic [3:0] OFS_MASK      = 4'h2;
   localparam logic [3:0] OFS_MODE_VIEW = 4'h3;
   localparam logic [3:0] OFS_BASE_VIEW = 4'h4;

   // Control fields
   localparam int CTL_DECODE_EN = 0;
   localparam int CTL_PORT_EN   = 1;
   localparam logic [7:0] CONTROL_RESET = 8'h03;
   localparam logic [7:0] MASK_RESET    = 8'h00;
   localparam logic [7:0] STATUS_RESET  = 8'h00;

   // Status and mask fields
   localparam int EV_ACCESS   = 0;
   localparam int EV_BAD_BASE = 1;
   localparam int EV_CTS_LOST = 2;
   localparam int EV_TX_START = 3;
   localparam int EV_IRQ      = 4;
   localparam int EV_COUNT    = 5;

   // Mode view fields
   localparam int MV_MODE_LSB = 0;
   localparam int MV_CTS      = 3;
   localparam int MV_DIR      = 4;
   localparam int MV_DRIVE    = 5;
   localparam int MV_LEGAL    = 7;

   // Host address map
   localparam int HOST_ADDR_W  = 10;
   localparam int BASE_SW_W    = 7;
   localparam int REG_SEL_W    = 3;
   localparam logic [9:0] BASE_MIN_WIDE   = 10'h100;
   localparam logic [9:0] BASE_MIN_NARROW = 10'h200;
   localparam logic [9:0] BASE_HOLE_LO    = 10'h1f0;
   localparam logic [9:0] BASE_HOLE_HI    = 10'h1f8;

   // Interrupt levels 2..7 as one-hot lanes
   localparam int IRQ_LANES = 6;

   typedef enum logic [2:0] {
      oneway_rx,
      oneway_tx,
      fullduplex,
      halfduplex_echo,
      halfduplex_noecho
   } mode_e;

endpackage : port_cfg_pkg

// *** hdl/rs485_port_config_decode.sv ***
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module rs485_port_config_decode
   import port_cfg_pkg::*;
(
   input  wire logic                   mclk,
   input  wire logic                   sys_rst,
   input  wire logic [REG_ADDR_W-1:0]  reg_addr,
   input  wire logic [REG_DATA_W-1:0]  reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic      [REG_DATA_W-1:0]  reg_rdata,
   output logic                        cfg_irq,
   input  wire logic [HOST_ADDR_W-1:0] io_addr,
   input  wire logic                   aen,
   input  wire logic                   host_16bit,
   input  wire logic [BASE_SW_W-1:0]   base_switch_on,
   input  wire logic                   cts_jumper,
   input  wire logic                   cts_external,
   input  wire logic                   rts_jumper_fitted,
   input  wire logic                   receiver_twoway_setting,
   input  wire logic                   simultaneous_twoway_setting,
   input  wire logic                   oneway_transmit_only,
   input  wire logic [2:0]             irq_level_select,
   input  wire logic                   uart_rts,
   input  wire logic                   uart_out2,
   input  wire logic                   uart_intr,
   input  wire logic                   uart_txd,
   input  wire logic                   line_rxd,
   output logic                        uart_cs,
   output logic      [REG_SEL_W-1:0]   uart_reg_sel,
   output logic                        uart_cts,
   output logic                        uart_rxd,
   output logic                        line_txd,
   output logic                        line_drive,
   output logic      [IRQ_LANES-1:0]   irq_lines
);

   logic [HOST_ADDR_W-1:0] base_addr;
   logic                   base_legal;
   logic                   addr_match;

   base_window_decode base_window_decode_inst (
      .io_addr        (io_addr),
      .aen            (aen),
      .base_switch_on (base_switch_on),
      .host_16bit     (host_16bit),
      .base_addr      (base_addr),
      .base_legal     (base_legal),
      .addr_match     (addr_match)
   );

   // Register file state
   logic [7:0]          control;
   logic [7:0]          mask;
   logic [7:0]          status;
   logic [7:0]          next_control;
   logic [7:0]          next_mask;
   logic [7:0]          next_status;
   logic [7:0]          next_rdata;
   logic [EV_COUNT-1:0] events;

   // Path state
   mode_e                mode;
   logic                 cts_any;
   logic                 dir_ctrl;
   logic                 line_active;
   logic                 cts_prev;
   logic                 next_cs;
   logic [REG_SEL_W-1:0] next_reg_sel;
   logic                 next_drive;
   logic                 next_rxd;
   logic                 next_txd;
   logic [IRQ_LANES-1:0] next_irq_lines;

   // Jumper strap combination picks the wiring mode
   always_comb begin
      unique case ({simultaneous_twoway_setting, receiver_twoway_setting})
         2'b11: mode = fullduplex;
         2'b10: mode = oneway_transmit_only ? oneway_tx : oneway_rx;
         2'b01: mode = halfduplex_echo;
         2'b00: mode = halfduplex_noecho;
      endcase
   end

   assign cts_any     = cts_jumper | cts_external;
   // Request-to-send never leaves the card, it only steers the driver
   assign dir_ctrl    = rts_jumper_fitted ? uart_rts : 1'b1;
   assign line_active = cts_any && control[CTL_PORT_EN];

   always_comb begin
      next_cs      = addr_match && base_legal && control[CTL_DECODE_EN];
      next_reg_sel = io_addr[2:0];
      next_drive   = 1'b0;
      next_rxd     = line_rxd;
      unique case (mode)
         oneway_rx: begin
            next_drive = 1'b0;
            next_rxd   = line_rxd;
         end
         oneway_tx: begin
            next_drive = line_active;
            next_rxd   = 1'b1;
         end
         fullduplex: begin
            next_drive = line_active;
            next_rxd   = line_rxd;
         end
         halfduplex_echo: begin
            next_drive = line_active && dir_ctrl;
            next_rxd   = next_drive ? uart_txd : line_rxd;
         end
         halfduplex_noecho: begin
            next_drive = line_active && dir_ctrl;
            next_rxd   = next_drive ? 1'b1 : line_rxd;
         end
      endcase
      // Idle mark level while the driver is off
      next_txd = next_drive ? uart_txd : 1'b1;
   end

   // Select values 6 and 7 have no jumper position and route nowhere
   always_comb begin
      next_irq_lines = '0;
      if (uart_out2 && uart_intr && (irq_level_select < 3'(IRQ_LANES))) begin
         next_irq_lines[irq_level_select] = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         uart_cs      <= 1'b0;
         uart_reg_sel <= '0;
         uart_cts     <= 1'b0;
         uart_rxd     <= 1'b1;
         line_txd     <= 1'b1;
         line_drive   <= 1'b0;
         irq_lines    <= '0;
         cts_prev     <= 1'b0;
      end else begin
         uart_cs      <= next_cs;
         uart_reg_sel <= next_reg_sel;
         uart_cts     <= cts_any;
         uart_rxd     <= next_rxd;
         line_txd     <= next_txd;
         line_drive   <= next_drive;
         irq_lines    <= next_irq_lines;
         cts_prev     <= cts_any;
      end
   end

   // Events raise sticky status bits
   always_comb begin
      events              = '0;
      events[EV_ACCESS]   = next_cs && !uart_cs;
      events[EV_BAD_BASE] = !base_legal;
      events[EV_CTS_LOST] = cts_prev && !cts_any;
      events[EV_TX_START] = next_drive && !line_drive;
      events[EV_IRQ]      = (|next_irq_lines) && !(|irq_lines);
   end

   always_comb begin
      next_control = control;
      next_mask    = mask;
      next_status  = status;
      next_rdata   = '0;
      if (reg_wr) begin
         unique case (reg_addr)
            OFS_CONTROL: next_control = reg_wdata;
            OFS_MASK:    next_mask    = reg_wdata;
            default:     next_control = control;
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            OFS_CONTROL: next_rdata = control;
            OFS_STATUS: begin
               next_rdata  = status;
               next_status = '0;
            end
            OFS_MASK:    next_rdata = mask;
            OFS_MODE_VIEW: begin
               next_rdata[MV_MODE_LSB +: 3] = 3'(mode);
               next_rdata[MV_CTS]           = cts_any;
               next_rdata[MV_DIR]           = dir_ctrl;
               next_rdata[MV_DRIVE]         = line_drive;
               next_rdata[MV_LEGAL]         = base_legal;
            end
            OFS_BASE_VIEW: next_rdata = {1'b0, base_addr[9:3]};
            default:     next_rdata = '0;
         endcase
      end
      // An event in the clearing read's cycle survives
      next_status[EV_COUNT-1:0] = next_status[EV_COUNT-1:0] | events;
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         control   <= CONTROL_RESET;
         mask      <= MASK_RESET;
         status    <= STATUS_RESET;
         reg_rdata <= '0;
      end else begin
         control   <= next_control;
         mask      <= next_mask;
         status    <= next_status;
         reg_rdata <= next_rdata;
      end
   end

   assign cfg_irq = |(status & mask);

   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   a_cts_blocks_tx: assert property (
      !cts_any |=> !line_drive && line_txd)
      else $error("driver on without clear-to-send");

   a_rts_steers_dir: assert property (
      (rts_jumper_fitted && !simultaneous_twoway_setting && line_active)
      |=> line_drive == $past(uart_rts))
      else $error("direction does not follow request-to-send");

   a_rts_held_high: assert property (
      (!rts_jumper_fitted && !simultaneous_twoway_setting && line_active) |=> line_drive)
      else $error("direction not held high without jumper");

   a_oneway_rx_only: assert property (
      (mode == oneway_rx) |=> !line_drive ##0 uart_rxd == $past(line_rxd))
      else $error("receive-only mode drove the line");

   a_full_duplex: assert property (
      (mode == fullduplex && line_active)
      |=> line_drive && uart_rxd == $past(line_rxd) && line_txd == $past(uart_txd))
      else $error("four-wire path wrong");

   a_alt_one_way: assert property (
      (!simultaneous_twoway_setting && rts_jumper_fitted && !uart_rts) |=> !line_drive)
      else $error("alternating mode drove with direction low");

   a_local_echo: assert property (
      (mode == halfduplex_echo && line_active && dir_ctrl) |=> uart_rxd == $past(uart_txd))
      else $error("own character not echoed");

   a_no_echo: assert property (
      (mode == halfduplex_noecho && line_active && dir_ctrl) |=> uart_rxd)
      else $error("echo not suppressed");

   a_irq_onehot: assert property (
      $onehot0(irq_lines))
      else $error("more than one interrupt level driven");

   a_irq_route: assert property (
      (uart_out2 && uart_intr && irq_level_select < 3'(IRQ_LANES))
      |=> irq_lines == (6'h01 << $past(irq_level_select)))
      else $error("interrupt level routing wrong");

   a_irq_gated: assert property (
      !uart_out2 |=> irq_lines == 6'h00)
      else $error("interrupt passed without enable output");

   a_cs_decode: assert property (
      uart_cs |-> $past(io_addr[9:3] == ~base_switch_on && !aen && control[CTL_DECODE_EN]))
      else $error("chip select without matching processor cycle");

   a_bad_base: assert property (
      (host_16bit && base_addr >= BASE_HOLE_LO && base_addr <= BASE_HOLE_HI) |=> !uart_cs)
      else $error("excluded base decoded");

   a_reg_select: assert property (
      ##1 uart_reg_sel == $past(io_addr[2:0]))
      else $error("register select not from low address");

   a_status_sticky: assert property (
      (events[EV_CTS_LOST]) |=> status[EV_CTS_LOST] ##1
      (status[EV_CTS_LOST] || $past(reg_rd && reg_addr == OFS_STATUS)))
      else $error("sticky status lost");

   a_status_clear: assert property (
      (reg_rd && reg_addr == OFS_STATUS && events == '0) |=> status == STATUS_RESET)
      else $error("status not cleared by its read");

   a_rdata_idle: assert property (
      !reg_rd |=> reg_rdata == 8'h00)
      else $error("read data present without a read");

   c_half_echo: cover property (mode == halfduplex_echo && line_drive ##1 !line_drive);
   c_full_duplex: cover property (mode == fullduplex && line_drive && uart_cs);
   c_irq_level4: cover property (irq_lines == 6'h04);
   c_status_read: cover property (cfg_irq ##1 reg_rd && reg_addr == OFS_STATUS);

endmodule : rs485_port_config_decode

// *** test/host_io_model.sv ***
`timescale 1ns/1ps
module host_io_model (
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       go,
   input  wire logic       dma,
   input  wire logic [9:0] addr_in,
   output logic      [9:0] io_addr,
   output logic            aen
);
   // Bus released between cycles: address churns so stale values never decode
   always_ff @(posedge mclk) begin
      if (rst) begin
         io_addr <= 10'h000;
         aen     <= 1'b1;
      end else if (go) begin
         io_addr <= addr_in;
         aen     <= dma;
      end else begin
         io_addr <= ~io_addr;
         aen     <= 1'b1;
      end
   end
endmodule : host_io_model

// *** test/tb_rs485_port_config_decode.sv ***
`timescale 1ns/1ps
module tb_rs485_port_config_decode;
   import port_cfg_pkg::*;
   logic       mclk, sys_rst, reg_wr, reg_rd, cfg_irq, aen, host_16bit, go, dma_in;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, rd;
   logic [9:0] io_addr, addr_in;
   logic [6:0] base_switch_on;
   logic       cts_jumper, cts_external, rts_jumper_fitted, receiver_twoway_setting;
   logic       simultaneous_twoway_setting, oneway_transmit_only, uart_rts, uart_out2;
   logic       uart_intr, uart_txd, line_rxd, uart_cs, uart_cts, uart_rxd, line_txd, line_drive;
   logic [2:0] irq_level_select, uart_reg_sel;
   logic [5:0] irq_lines;
   logic [10:0] rows [8];
   logic [9:0] bases [4];
   int         err_count = 0;
   int         checked = 0;

   rs485_port_config_decode rs485_port_config_decode_inst (
      .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cfg_irq(cfg_irq),
      .io_addr(io_addr), .aen(aen), .host_16bit(host_16bit),
      .base_switch_on(base_switch_on), .cts_jumper(cts_jumper),
      .cts_external(cts_external), .rts_jumper_fitted(rts_jumper_fitted),
      .receiver_twoway_setting(receiver_twoway_setting),
      .simultaneous_twoway_setting(simultaneous_twoway_setting),
      .oneway_transmit_only(oneway_transmit_only), .irq_level_select(irq_level_select),
      .uart_rts(uart_rts), .uart_out2(uart_out2), .uart_intr(uart_intr),
      .uart_txd(uart_txd), .line_rxd(line_rxd), .uart_cs(uart_cs),
      .uart_reg_sel(uart_reg_sel), .uart_cts(uart_cts), .uart_rxd(uart_rxd),
      .line_txd(line_txd), .line_drive(line_drive), .irq_lines(irq_lines));
   host_io_model host_io_model_inst (.mclk(mclk), .rst(sys_rst), .go(go), .dma(dma_in),
      .addr_in(addr_in), .io_addr(io_addr), .aen(aen));

   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   task automatic check(input string nm, input logic [9:0] exp, input logic [9:0] got);
      checked++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
         err_count++;
      end
   endtask : check

   task automatic tally_and_finish;
      $display("checked %0d err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : tally_and_finish

   task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : reg_write

   task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
      @(posedge mclk);
      reg_rd <= 1'b1; reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : reg_read

   // One host cycle, then chip select one cycle after the address stands
   task automatic hit(input logic [9:0] base, input logic wide, input logic [9:0] a,
                      input logic dma, input logic exp);
      @(posedge mclk);
      base_switch_on <= ~base[9:3]; host_16bit <= wide;
      go <= 1'b1; addr_in <= a; dma_in <= dma;
      @(posedge mclk);
      go <= 1'b0;
      @(posedge mclk);
      #1 check("uart_cs", {9'h0, exp}, {9'h0, uart_cs});
      if (exp) check("uart_reg_sel", {7'h0, a[2:0]}, {7'h0, uart_reg_sel});
   endtask : hit

   initial begin
      // {cts,twoway,simult,tx_only,rts_fit,rts,txd,line_rxd, drive,line_txd,uart_rxd}
      rows = '{11'b11101000_100, 11'b10100100_010, 11'b10110000_101, 11'b11001101_100,
               11'b11001001_011, 11'b10001100_101, 11'b10000001_101, 11'b01101001_011};
      bases = '{10'h3f8, 10'h2f8, 10'h3e8, 10'h2e8};
      sys_rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0; reg_wdata = 8'h00;
      go = 1'b0; dma_in = 1'b1; addr_in = 10'h000; host_16bit = 1'b1;
      base_switch_on = ~7'h5b; cts_jumper = 1'b1; cts_external = 1'b0;
      rts_jumper_fitted = 1'b1; receiver_twoway_setting = 1'b1;
      simultaneous_twoway_setting = 1'b0; oneway_transmit_only = 1'b0;
      uart_rts = 1'b0; uart_out2 = 1'b0; uart_intr = 1'b0; uart_txd = 1'b1; line_rxd = 1'b1;
      irq_level_select = 3'h0;
      repeat (5) @(posedge mclk);
      sys_rst <= 1'b0;
      reg_read(OFS_CONTROL, rd); check("control", {2'h0, CONTROL_RESET}, {2'h0, rd});
      reg_read(OFS_MASK, rd);    check("mask", {2'h0, MASK_RESET}, {2'h0, rd});
      reg_read(4'hf, rd);        check("unmapped", 10'h0, {2'h0, rd});
      reg_write(OFS_BASE_VIEW, 8'hff);
      reg_read(OFS_BASE_VIEW, rd); check("base_view", 10'h05b, {2'h0, rd});
      reg_read(OFS_MODE_VIEW, rd); check("mode_view", 10'h08b, {2'h0, rd});
      reg_read(OFS_STATUS, rd);
      reg_read(OFS_STATUS, rd);  check("status_clear", 10'h0, {2'h0, rd});
      for (int i = 0; i < 8; i++) begin
         @(posedge mclk);
         cts_jumper <= rows[i][10] & ~i[0]; cts_external <= rows[i][10] & i[0];
         receiver_twoway_setting <= rows[i][9]; simultaneous_twoway_setting <= rows[i][8];
         oneway_transmit_only <= rows[i][7]; rts_jumper_fitted <= rows[i][6];
         uart_rts <= rows[i][5]; uart_txd <= rows[i][4]; line_rxd <= rows[i][3];
         repeat (2) @(posedge mclk);
         #1 check("line_drive", {9'h0, rows[i][2]}, {9'h0, line_drive});
         check("line_txd", {9'h0, rows[i][1]}, {9'h0, line_txd});
         check("uart_rxd", {9'h0, rows[i][0]}, {9'h0, uart_rxd});
         check("uart_cts", {9'h0, rows[i][10]}, {9'h0, uart_cts});
      end
      @(posedge mclk);
      cts_jumper <= 1'b1;
      repeat (2) @(posedge mclk);
      #1 check("line_drive_on", 10'h1, {9'h0, line_drive});
      // Port enable cleared in full-duplex: driver must drop despite clear-to-send
      reg_write(OFS_CONTROL, 8'h01);
      repeat (2) @(posedge mclk);
      #1 check("line_drive_off", 10'h0, {9'h0, line_drive});
      reg_write(OFS_CONTROL, 8'h03);
      hit(10'h2d8, 1'b1, 10'h2dd, 1'b0, 1'b1);
      hit(10'h2d8, 1'b1, 10'h2dd, 1'b1, 1'b0);
      hit(10'h2d8, 1'b1, 10'h2e5, 1'b0, 1'b0);
      for (int i = 0; i < 4; i++) hit(bases[i], 1'b0, bases[i] + 10'(i), 1'b0, 1'b1);
      hit(10'h100, 1'b1, 10'h107, 1'b0, 1'b1);
      hit(10'h100, 1'b0, 10'h107, 1'b0, 1'b0);
      hit(10'h1f0, 1'b1, 10'h1f2, 1'b0, 1'b0);
      hit(10'h1f8, 1'b1, 10'h1f9, 1'b0, 1'b0);
      hit(10'h1e8, 1'b1, 10'h1e8, 1'b0, 1'b1);
      hit(10'h200, 1'b0, 10'h203, 1'b0, 1'b1);
      reg_write(OFS_CONTROL, 8'h02);
      hit(10'h2d8, 1'b1, 10'h2d8, 1'b0, 1'b0);
      reg_write(OFS_CONTROL, 8'h03);
      reg_read(OFS_STATUS, rd);
      reg_write(OFS_MASK, 8'h01);
      hit(10'h2d8, 1'b1, 10'h2d9, 1'b0, 1'b1);
      check("cfg_irq_set", 10'h1, {9'h0, cfg_irq});
      reg_read(OFS_STATUS, rd);  check("status_access", 10'h1, {9'h0, rd[EV_ACCESS]});
      @(posedge mclk);
      #1 check("cfg_irq_clear", 10'h0, {9'h0, cfg_irq});
      reg_write(OFS_MASK, 8'h00);
      hit(10'h2d8, 1'b1, 10'h2da, 1'b0, 1'b1);
      check("cfg_irq_masked", 10'h0, {9'h0, cfg_irq});
      for (int l = 0; l < 8; l++) begin
         @(posedge mclk);
         irq_level_select <= 3'(l); uart_out2 <= 1'b1; uart_intr <= 1'b1;
         repeat (2) @(posedge mclk);
         #1 check("irq_lines", (l < 6) ? 10'(1) << l : 10'h0, {4'h0, irq_lines});
      end
      @(posedge mclk);
      irq_level_select <= 3'h1; uart_out2 <= 1'b0;
      repeat (2) @(posedge mclk);
      #1 check("irq_gated", 10'h0, {4'h0, irq_lines});
      // Mid-run reset from a live full-duplex, interrupting state
      @(posedge mclk);
      sys_rst <= 1'b1; uart_out2 <= 1'b1; line_rxd <= 1'b0;
      repeat (2) @(posedge mclk);
      #1 check("rst_line_drive", 10'h0, {9'h0, line_drive});
      check("rst_irq_lines", 10'h0, {4'h0, irq_lines});
      check("rst_uart_rxd", 10'h1, {9'h0, uart_rxd});
      check("rst_line_txd", 10'h1, {9'h0, line_txd});
      // Quiet inputs before release so one-cycle properties see only reset values
      @(posedge mclk);
      cts_jumper <= 1'b0; uart_out2 <= 1'b0;
      @(posedge mclk);
      sys_rst <= 1'b0;
      reg_read(OFS_CONTROL, rd); check("control_again", {2'h0, CONTROL_RESET}, {2'h0, rd});
      tally_and_finish();
   end

   initial begin
      repeat (5000) @(posedge mclk);
      err_count++;
      tally_and_finish();
   end
endmodule : tb_rs485_port_config_decode
